// ---- rtl/kick_hold_channel.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "kick_hold_map.svh"

module kick_hold_channel
(
	input wire logic clk_i,
	input wire logic srst_i,
	input wire logic step_tick_i,
	input wire logic [3:0] slot_idx_i,
	input wire logic act_i,
	input wire logic [`KH_KICK_W-1:0] kick_units_i,
	input wire logic [`KH_DUTY_W-1:0] duty_i,
	output logic drive_o,
	output logic holding_o
);

	kick_hold_pkg::ch_state_t state_q, state_d;
	logic [`KH_KICK_W-1:0] cnt_q, cnt_d;
	logic drive_q, drive_d;
	logic pwm_on;

	// Slot index below duty tenths; duty 0 never drives, 10 always drives
	assign pwm_on = slot_idx_i < duty_i;

	////////////////////////////////////////////////////////////////////////
	// Next state; the step tick is free running, so the kick counts one
	// extra tick to guarantee at least the programmed interval
	always_comb
	begin
		state_d = state_q;
		cnt_d = cnt_q;
		drive_d = 1'b0;
		unique case (state_q)
			kick_hold_pkg::CH_IDLE:
			begin
				if (act_i)
				begin
					state_d = kick_hold_pkg::CH_KICK;
					cnt_d = '0;
					drive_d = 1'b1;
				end
			end
			kick_hold_pkg::CH_KICK:
			begin
				if (!act_i)
					state_d = kick_hold_pkg::CH_IDLE;
				else
				begin
					drive_d = 1'b1;
					if (step_tick_i)
					begin
						if (cnt_q >= kick_units_i)
						begin
							state_d = kick_hold_pkg::CH_HOLD;
							drive_d = pwm_on;
						end
						else
							cnt_d = cnt_q + 1'b1;
					end
				end
			end
			kick_hold_pkg::CH_HOLD:
			begin
				if (!act_i)
					state_d = kick_hold_pkg::CH_IDLE;
				else
					drive_d = pwm_on;
			end
			default:
				state_d = kick_hold_pkg::CH_IDLE;
		endcase
	end

	// State registers
	always_ff @(posedge clk_i)
	begin
		if (srst_i)
		begin
			state_q <= kick_hold_pkg::CH_IDLE;
			cnt_q <= '0;
			drive_q <= 1'b0;
		end
		else
		begin
			state_q <= state_d;
			cnt_q <= cnt_d;
			drive_q <= drive_d;
		end
	end

	assign drive_o = drive_q;
	assign holding_o = (state_q == kick_hold_pkg::CH_HOLD);

	////////////////////////////////////////////////////////////////////////
	// Checks
	AST_OFF_ON_WITHDRAW: assert property (@(posedge clk_i) disable iff (srst_i)
		!act_i |=> !drive_o)
		else $error("output still driven after command withdrawn");

	AST_RESTART_KICK: assert property (@(posedge clk_i) disable iff (srst_i)
		(state_q == kick_hold_pkg::CH_IDLE && act_i) |=> (state_q == kick_hold_pkg::CH_KICK && drive_o))
		else $error("activation did not start full-on phase");

	AST_KICK_FULL_ON: assert property (@(posedge clk_i) disable iff (srst_i)
		(state_q == kick_hold_pkg::CH_KICK && act_i && !step_tick_i) |=> drive_o)
		else $error("output not fully on during kick");

	AST_KICK_END: assert property (@(posedge clk_i) disable iff (srst_i)
		(state_q == kick_hold_pkg::CH_KICK && act_i && step_tick_i && cnt_q >= kick_units_i)
		|=> state_q == kick_hold_pkg::CH_HOLD)
		else $error("kick did not end at programmed count");

	AST_HOLD_PWM: assert property (@(posedge clk_i) disable iff (srst_i)
		(state_q == kick_hold_pkg::CH_HOLD && act_i) |=> drive_o == $past(pwm_on))
		else $error("hold drive does not follow duty");

endmodule // kick_hold_channel

`default_nettype wire

// ---- rtl/kick_hold_map.svh ----
`ifndef KICK_HOLD_MAP_SVH
`define KICK_HOLD_MAP_SVH

// Channel count and the channels that carry non-uniform defaults
`define KH_CH_NUM 14
`define KH_CH_REV 0
`define KH_CH_FOOT 1
`define KH_CH_RIGHT 6

// Register byte offsets on the Avalon-MM slave
`define KH_REG_CTRL 8'h00
`define KH_REG_STATUS 8'h04
`define KH_REG_CMD 8'h08
`define KH_CH_BASE_SEL 2'h1
`define KH_ADDR_W 8
`define KH_DATA_W 32

// Channel register fields
`define KH_KICK_LSB 0
`define KH_KICK_W 8
`define KH_DUTY_LSB 8
`define KH_DUTY_W 4
`define KH_CTRL_KEEP_REV_BIT 0
`define KH_STATUS_HOLD_LSB 16

// Full-on interval limits in 4 ms units, hold duty in tenths
`define KH_KICK_MIN 8'h01
`define KH_DUTY_MAX 4'hA
`define KH_SLOT_LAST 4'h9

// Reset values
`define KH_KICK_DEF_REV 8'hFF
`define KH_KICK_DEF_FOOT 8'h32
`define KH_KICK_DEF_OTHER 8'h19
`define KH_DUTY_DEF_REV 4'h5
`define KH_DUTY_DEF_FOOT 4'h2
`define KH_DUTY_DEF_RIGHT 4'h5
`define KH_DUTY_DEF_OTHER 4'hA
`define KH_KEEP_REV_DEF 1'b0

// Timing: clock rate, kick step and PWM slot
`define KH_CLK_MHZ 125
`define KH_STEP_MS 4
`define KH_STEP_CYCLES (`KH_STEP_MS * 1000 * `KH_CLK_MHZ)
`define KH_SLOT_US 10
`define KH_SLOT_CYCLES (`KH_SLOT_US * `KH_CLK_MHZ)

`endif

// ---- rtl/kick_hold_pkg.sv ----
package kick_hold_pkg;

	// Gray path: idle -> kick -> hold
	typedef enum logic [1:0] {
		CH_IDLE = 2'b00,
		CH_KICK = 2'b01,
		CH_HOLD = 2'b11
	} ch_state_t;

endpackage

// ---- rtl/solenoid_kick_hold_driver.sv ----
// Overview of operation
// - Per-channel full-on time, 4..1020 ms, 4 ms steps
// - Activation drives channel fully on for interval
// - Then PWM hold, duty 0..100 % in 10 % steps
// - Full-on defaults 1020, 200, else 100 ms
// - Duty defaults 50, 20, right 50, else 100
// - Fourteen separately configured output channels
// - Option keeps reverse solenoid on during trimming
//
// The placing of the registers and the Avalon-MM slave port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "kick_hold_map.svh"

module solenoid_kick_hold_driver
#(
	parameter int STEP_CYCLES = `KH_STEP_CYCLES,
	parameter int SLOT_CYCLES = `KH_SLOT_CYCLES
)
(
	input wire logic clk_i,
	input wire logic srst_i,
	input wire logic [`KH_ADDR_W-1:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [`KH_DATA_W-1:0] avs_writedata_i,
	input wire logic [3:0] avs_byteenable_i,
	output logic [`KH_DATA_W-1:0] avs_readdata_o,
	output logic avs_waitrequest_o,
	input wire logic [`KH_CH_NUM-1:0] chan_cmd_i,
	input wire logic trim_active_i,
	output logic [`KH_CH_NUM-1:0] chan_drive_o
);

	localparam int STEP_W = $clog2(STEP_CYCLES);
	localparam int SLOT_W = $clog2(SLOT_CYCLES);

	logic [STEP_W-1:0] step_cnt_q, step_cnt_d;
	logic [SLOT_W-1:0] slot_cnt_q, slot_cnt_d;
	logic [3:0] slot_idx_q, slot_idx_d;
	logic step_tick;
	logic slot_tick;

	logic [`KH_KICK_W-1:0] kick_q [`KH_CH_NUM];
	logic [`KH_KICK_W-1:0] kick_d [`KH_CH_NUM];
	logic [`KH_DUTY_W-1:0] duty_q [`KH_CH_NUM];
	logic [`KH_DUTY_W-1:0] duty_d [`KH_CH_NUM];
	logic keep_rev_q, keep_rev_d;

	logic ack_q, ack_d;
	logic [`KH_DATA_W-1:0] rdata_q, rdata_d;
	logic req;
	logic wr_commit;
	logic ch_hit;
	logic [3:0] ch_idx;
	logic [`KH_CH_NUM-1:0] act_w;
	logic [`KH_CH_NUM-1:0] hold_w;

	////////////////////////////////////////////////////////////////////////
	// Timebase: 4 ms step tick and PWM slot tick with a 0..9 slot index
	assign step_tick = (step_cnt_q == STEP_W'(STEP_CYCLES - 1));
	assign slot_tick = (slot_cnt_q == SLOT_W'(SLOT_CYCLES - 1));

	always_comb
	begin
		step_cnt_d = step_tick ? '0 : step_cnt_q + 1'b1;
		slot_cnt_d = slot_tick ? '0 : slot_cnt_q + 1'b1;
		slot_idx_d = slot_idx_q;
		if (slot_tick)
			slot_idx_d = (slot_idx_q == `KH_SLOT_LAST) ? 4'h0 : slot_idx_q + 4'h1;
	end

	always_ff @(posedge clk_i)
	begin
		if (srst_i)
		begin
			step_cnt_q <= '0;
			slot_cnt_q <= '0;
			slot_idx_q <= 4'h0;
		end
		else
		begin
			step_cnt_q <= step_cnt_d;
			slot_cnt_q <= slot_cnt_d;
			slot_idx_q <= slot_idx_d;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Avalon slave: every access takes exactly one wait cycle, so read
	// data is registered before waitrequest drops and the write lands on
	// the edge where the master sees waitrequest low
	assign req = avs_read_i | avs_write_i;
	assign avs_waitrequest_o = req & ~ack_q;
	assign wr_commit = avs_write_i & ack_q;
	assign ch_idx = avs_address_i[5:2];
	assign ch_hit = (avs_address_i[7:6] == `KH_CH_BASE_SEL) && (avs_address_i[1:0] == 2'h0)
		&& (ch_idx < 4'(`KH_CH_NUM));

	// Read mux; unmapped addresses read as zero
	always_comb
	begin
		ack_d = req & ~ack_q;
		rdata_d = rdata_q;
		if (avs_read_i && !ack_q)
		begin
			rdata_d = '0;
			if (ch_hit)
			begin
				rdata_d[`KH_KICK_LSB +: `KH_KICK_W] = kick_q[ch_idx];
				rdata_d[`KH_DUTY_LSB +: `KH_DUTY_W] = duty_q[ch_idx];
			end
			else if (avs_address_i == `KH_REG_CTRL)
				rdata_d[`KH_CTRL_KEEP_REV_BIT] = keep_rev_q;
			else if (avs_address_i == `KH_REG_STATUS)
			begin
				rdata_d[`KH_CH_NUM-1:0] = chan_drive_o;
				rdata_d[`KH_STATUS_HOLD_LSB +: `KH_CH_NUM] = hold_w;
			end
			else if (avs_address_i == `KH_REG_CMD)
				rdata_d[`KH_CH_NUM-1:0] = act_w;
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (srst_i)
		begin
			ack_q <= 1'b0;
			rdata_q <= '0;
		end
		else
		begin
			ack_q <= ack_d;
			rdata_q <= rdata_d;
		end
	end

	assign avs_readdata_o = rdata_q;

	////////////////////////////////////////////////////////////////////////
	// Configuration writes, clamped into the legal range so a bad value
	// can never give a zero-length kick or an out-of-range duty
	always_comb
	begin
		keep_rev_d = keep_rev_q;
		for (int i = 0; i < `KH_CH_NUM; i++)
		begin
			kick_d[i] = kick_q[i];
			duty_d[i] = duty_q[i];
		end
		if (wr_commit && ch_hit)
		begin
			if (avs_byteenable_i[0])
			begin
				if (avs_writedata_i[`KH_KICK_LSB +: `KH_KICK_W] == 8'h00)
					kick_d[ch_idx] = `KH_KICK_MIN;
				else
					kick_d[ch_idx] = avs_writedata_i[`KH_KICK_LSB +: `KH_KICK_W];
			end
			if (avs_byteenable_i[1])
			begin
				if (avs_writedata_i[`KH_DUTY_LSB +: `KH_DUTY_W] > `KH_DUTY_MAX)
					duty_d[ch_idx] = `KH_DUTY_MAX;
				else
					duty_d[ch_idx] = avs_writedata_i[`KH_DUTY_LSB +: `KH_DUTY_W];
			end
		end
		if (wr_commit && avs_address_i == `KH_REG_CTRL && avs_byteenable_i[0])
			keep_rev_d = avs_writedata_i[`KH_CTRL_KEEP_REV_BIT];
	end

	// Reset loads per-channel defaults
	always_ff @(posedge clk_i)
	begin
		if (srst_i)
		begin
			keep_rev_q <= `KH_KEEP_REV_DEF;
			for (int i = 0; i < `KH_CH_NUM; i++)
			begin
				kick_q[i] <= `KH_KICK_DEF_OTHER;
				duty_q[i] <= `KH_DUTY_DEF_OTHER;
			end
			kick_q[`KH_CH_REV] <= `KH_KICK_DEF_REV;
			kick_q[`KH_CH_FOOT] <= `KH_KICK_DEF_FOOT;
			duty_q[`KH_CH_REV] <= `KH_DUTY_DEF_REV;
			duty_q[`KH_CH_FOOT] <= `KH_DUTY_DEF_FOOT;
			duty_q[`KH_CH_RIGHT] <= `KH_DUTY_DEF_RIGHT;
		end
		else
		begin
			keep_rev_q <= keep_rev_d;
			for (int i = 0; i < `KH_CH_NUM; i++)
			begin
				kick_q[i] <= kick_d[i];
				duty_q[i] <= duty_d[i];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Effective activation: the reverse solenoid may be held by trimming
	assign act_w = chan_cmd_i
		| {{(`KH_CH_NUM-1){1'b0}}, keep_rev_q & trim_active_i};

	// One independent kick-and-hold engine per channel
	for (genvar g = 0; g < `KH_CH_NUM; g++)
	begin : g_chan
		kick_hold_channel u_chan
		(
			.clk_i(clk_i),
			.srst_i(srst_i),
			.step_tick_i(step_tick),
			.slot_idx_i(slot_idx_q),
			.act_i(act_w[g]),
			.kick_units_i(kick_q[g]),
			.duty_i(duty_q[g]),
			.drive_o(chan_drive_o[g]),
			.holding_o(hold_w[g])
		);
	end

	////////////////////////////////////////////////////////////////////////
	// Checks
	AST_DEF_KICK: assert property (@(posedge clk_i)
		srst_i |=> (kick_q[`KH_CH_REV] == `KH_KICK_DEF_REV && kick_q[`KH_CH_FOOT] == `KH_KICK_DEF_FOOT
		&& kick_q[2] == `KH_KICK_DEF_OTHER))
		else $error("full-on defaults wrong after reset");

	AST_DEF_DUTY: assert property (@(posedge clk_i)
		srst_i |=> (duty_q[`KH_CH_REV] == `KH_DUTY_DEF_REV && duty_q[`KH_CH_FOOT] == `KH_DUTY_DEF_FOOT
		&& duty_q[`KH_CH_RIGHT] == `KH_DUTY_DEF_RIGHT && duty_q[5] == `KH_DUTY_DEF_OTHER))
		else $error("duty defaults wrong after reset");

	// Energised means kicking or in the hold phase; PWM may be low in hold
	AST_TRIM_KEEP: assert property (@(posedge clk_i) disable iff (srst_i)
		(keep_rev_q && trim_active_i) |=> (chan_drive_o[`KH_CH_REV] || hold_w[`KH_CH_REV]))
		else $error("reverse solenoid dropped during trimming");

	AST_TRIM_OFF: assert property (@(posedge clk_i) disable iff (srst_i)
		(!keep_rev_q && !chan_cmd_i[`KH_CH_REV]) |=> !chan_drive_o[`KH_CH_REV])
		else $error("reverse solenoid held with option clear");

	AST_BUS_ONE_WAIT: assert property (@(posedge clk_i) disable iff (srst_i)
		(req && avs_waitrequest_o) |=> !avs_waitrequest_o)
		else $error("bus access not answered after one wait cycle");

	AST_DUTY_RANGE: assert property (@(posedge clk_i) disable iff (srst_i)
		wr_commit |=> (duty_q[0] <= `KH_DUTY_MAX && kick_q[0] >= `KH_KICK_MIN))
		else $error("channel setting outside legal range");

endmodule // solenoid_kick_hold_driver

`default_nettype wire

// ---- verif/load_model.sv ----
`timescale 1ns/1ps
`default_nettype none

// Load side: integrates energised cycles of one watched channel
module load_model
(
	input wire logic clk_i,
	input wire logic clr_i,
	input wire logic [3:0] sel_i,
	input wire logic [13:0] drive_i,
	output logic [7:0] on_cnt_o
);
	// Saturates, so a long window cannot wrap into a false match
	always_ff @(posedge clk_i)
	begin
		if (clr_i)
			on_cnt_o <= 8'h00;
		else if (drive_i[sel_i] && on_cnt_o != 8'hFF)
			on_cnt_o <= on_cnt_o + 8'h01;
	end
endmodule // load_model

`default_nettype wire

// ---- verif/testbench.sv ----
`timescale 1ns/1ps
`default_nettype none

module testbench;
	logic clk_i = 1'b0;
	logic srst_i = 1'b1;
	logic [7:0] avs_address_i = 8'h00;
	logic avs_read_i = 1'b0;
	logic avs_write_i = 1'b0;
	logic [31:0] avs_writedata_i = 32'h00000000;
	logic [31:0] avs_readdata_o;
	logic avs_waitrequest_o;
	logic [13:0] chan_cmd_i = 14'h0000;
	logic trim_active_i = 1'b0;
	logic [13:0] chan_drive_o;
	logic clr = 1'b1;
	logic [3:0] sel = 4'h0;
	logic [7:0] on_cnt;
	logic [31:0] rd;
	int fail_count = 0;
	int samples_checked = 0;
	int seed = 32'h448AB45C;
	int i;

	// Short counts: 8-cycle kick step, 40-cycle PWM period
	solenoid_kick_hold_driver #(.STEP_CYCLES(8), .SLOT_CYCLES(4)) solenoid_kick_hold_driver_i (
		.clk_i(clk_i), .srst_i(srst_i), .avs_address_i(avs_address_i),
		.avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
		.avs_writedata_i(avs_writedata_i), .avs_byteenable_i(4'hF),
		.avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
		.chan_cmd_i(chan_cmd_i), .trim_active_i(trim_active_i), .chan_drive_o(chan_drive_o));

	load_model load_model_i (.clk_i(clk_i), .clr_i(clr), .sel_i(sel),
		.drive_i(chan_drive_o), .on_cnt_o(on_cnt));

	always #4 clk_i = ~clk_i;

	////////////////////////////////////////////////////////////////
	task automatic final_report();
		$display("checks %0d mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
		samples_checked++;
		if (got !== exp)
		begin
			$display("CHECK FAILED t=%0t %s got %h exp %h", $time, m, got, exp);
			fail_count++;
		end
	endtask

	// Reset value of a channel register: {duty tenths, kick units}
	function automatic logic [11:0] def_val(input int n);
		logic [3:0] d;
		logic [7:0] k;
		d = (n == 0 || n == 6) ? 4'h5 : (n == 1) ? 4'h2 : 4'hA;
		k = (n == 0) ? 8'hFF : (n == 1) ? 8'h32 : 8'h19;
		return {d, k};
	endfunction

	// One Avalon transfer; entered just after a rising edge.
	// Waitrequest is sampled mid-cycle, so the accept edge is the next rise.
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd,
		output logic [31:0] rdat);
		int n;
		n = 0;
		avs_address_i <= a;
		avs_writedata_i <= wd;
		avs_write_i <= wr;
		avs_read_i <= !wr;
		do
		begin
			@(negedge clk_i);
			n++;
		end
		while (avs_waitrequest_o !== 1'b0 && n < 20);
		if (n >= 20)
		begin
			$display("CHECK FAILED t=%0t bus hang", $time);
			fail_count++;
			final_report();
		end
		@(posedge clk_i);
		rdat = avs_readdata_o;
		avs_read_i <= 1'b0;
		avs_write_i <= 1'b0;
		// Let an edge pass so a following call never reassigns the strobes
		@(posedge clk_i);
	endtask

	// Program a channel, activate, check kick, hold duty, then withdraw
	task automatic kick_test(input int ch, input logic [7:0] u, input logic [3:0] d);
		int k;
		logic [31:0] r;
		bus(1'b1, 8'h40 + 8'(ch * 4), {20'h00000, d, u}, r);
		bus(1'b0, 8'h40 + 8'(ch * 4), 32'h00000000, r);
		chk({20'h00000, r[11:0]}, {20'h00000, d, u}, "chan reg");
		sel <= 4'(ch);
		chan_cmd_i[ch] <= 1'b1;
		@(posedge clk_i);
		for (k = 0; k < int'(u) * 8; k++)
		begin
			@(negedge clk_i);
			if (chan_drive_o[ch] !== 1'b1)
				break;
		end
		chk({31'h0, chan_drive_o[ch]}, 32'h1, "full-on too short");
		repeat (10) @(posedge clk_i);
		clr <= 1'b1;
		@(posedge clk_i);
		clr <= 1'b0;
		repeat (40) @(posedge clk_i);
		@(negedge clk_i);
		chk({24'h000000, on_cnt}, 32'(d) * 4, "hold duty");
		@(posedge clk_i);
		bus(1'b0, 8'h04, 32'h00000000, r);
		chk({31'h0, r[16 + ch]}, 32'h1, "hold status");
		chan_cmd_i[ch] <= 1'b0;
		@(posedge clk_i);
		@(negedge clk_i);
		chk({31'h0, chan_drive_o[ch]}, 32'h0, "not off");
		@(posedge clk_i);
	endtask

	////////////////////////////////////////////////////////////////
	initial
	begin
		repeat (16) @(posedge clk_i);
		srst_i <= 1'b0;
		@(posedge clk_i);
		// Reset values of every channel and the option bit
		for (i = 0; i < 14; i++)
		begin
			bus(1'b0, 8'h40 + 8'(i * 4), 32'h00000000, rd);
			chk({20'h00000, rd[11:0]}, {20'h00000, def_val(i)}, "default");
		end
		bus(1'b0, 8'h00, 32'h00000000, rd);
		chk({31'h0, rd[0]}, 32'h0, "option default");
		bus(1'b0, 8'h3C, 32'h00000000, rd);
		chk(rd, 32'h00000000, "unmapped read");
		// Out-of-range writes are clamped to the legal limits
		bus(1'b1, 8'h44, 32'h00000F00, rd);
		bus(1'b0, 8'h44, 32'h00000000, rd);
		chk({20'h00000, rd[11:0]}, 32'h00000A01, "clamp");
		// Corners, then random channels; re-activation re-kicks
		kick_test(13, 8'h01, 4'h0);
		kick_test(2, 8'h04, 4'hA);
		kick_test(2, 8'h02, 4'h3);
		repeat (6)
			kick_test(1 + ($unsigned($random(seed)) % 13), 8'(1 + ($unsigned($random(seed)) % 4)),
				4'($unsigned($random(seed)) % 11));
		// Trimming holds the reverse channel only with the option set
		trim_active_i <= 1'b1;
		repeat (3) @(posedge clk_i);
		@(negedge clk_i);
		chk({31'h0, chan_drive_o[0]}, 32'h0, "trim without option");
		@(posedge clk_i);
		bus(1'b1, 8'h00, 32'h00000001, rd);
		repeat (3) @(posedge clk_i);
		@(negedge clk_i);
		chk({31'h0, chan_drive_o[0]}, 32'h1, "trim keep");
		@(posedge clk_i);
		bus(1'b0, 8'h00, 32'h00000000, rd);
		chk({31'h0, rd[0]}, 32'h1, "option readback");
		bus(1'b0, 8'h08, 32'h00000000, rd);
		chk(rd, 32'h00000001, "trim activation");
		// Reverse channel still kicking: driven, not yet holding
		bus(1'b0, 8'h04, 32'h00000000, rd);
		chk(rd, 32'h00000001, "status during kick");
		trim_active_i <= 1'b0;
		repeat (2) @(posedge clk_i);
		@(negedge clk_i);
		chk({31'h0, chan_drive_o[0]}, 32'h0, "trim end");
		@(posedge clk_i);
		final_report();
	end
endmodule // testbench

`default_nettype wire
